// ==== verilog/cbt_bit_timing.sv ====
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - timing registers readable always, writable in init
// - jump width field gives 1..4 quanta
// - prescaler divides the selected clock (bus clock or oscillator tick) by field plus one
// - single sampling takes sample-point value
// - triple sampling uses majority of three
// - second segment is field plus one quanta
// - first segment is field plus one quanta
// - bit time is prescale times quanta count
// - flag cleared by one, only when cause gone
// - each flag has its own interrupt enable
// - init active when request and acknowledge set
// - clock select: oscillator or bus clock
module cbt_bit_timing (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // clock source and bus line
  input  wire logic        i_osc_tick,
  input  wire logic        i_can_rx,
  // timing results
  output logic             o_tq_tick,
  output logic             o_sample_pt,
  output logic             o_rx_bit,
  output logic             o_irq
);
  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  cbt_pkg::cbt_prescale_jump_t btr0_r, btr0_nxt;
  cbt_pkg::cbt_segments_t      btr1_r, btr1_nxt;
  logic       req_r, req_nxt, ack_r, sel_r, sel_nxt;
  logic [cbt_pkg::NUM_FLAGS-1:0] flg_r, flg_nxt, ien_r, ien_nxt, evt;
  logic       wr_q_r, wr_q_nxt;
  logic [7:0] wa_r, wa_nxt;
  logic [31:0] rd_nxt;
  logic       irq_nxt, init_act, wr_en;
  logic [31:0] wd;

  assign init_act = req_r & ack_r;
  assign wd       = i_hwdata;
  assign wr_en    = wr_q_r;

  // bus decode, register writes and read mux
  always_comb begin
    wr_q_nxt = i_hready & i_hsel & i_htrans == cbt_pkg::HTRANS_NONSEQ & i_hwrite;
    wa_nxt   = i_hready ? i_haddr : wa_r;
    btr0_nxt = btr0_r;
    btr1_nxt = btr1_r;
    req_nxt  = req_r;
    sel_nxt  = sel_r;
    ien_nxt  = ien_r;
    // set beats clear, so a flag is only dropped once its cause is gone
    flg_nxt  = flg_r;
    if (wr_en && init_act) begin
      if (wa_r == cbt_pkg::OFF_BTR0) btr0_nxt = wd[7:0];
      if (wa_r == cbt_pkg::OFF_BTR1) btr1_nxt = wd[7:0];
      if (wa_r == cbt_pkg::OFF_CTL) sel_nxt = wd[cbt_pkg::CTL_SEL_BIT];
    end
    if (wr_en && wa_r == cbt_pkg::OFF_CTL) begin
      // request may only drop once acknowledged
      if (wd[cbt_pkg::CTL_REQ_BIT] || ack_r) req_nxt = wd[cbt_pkg::CTL_REQ_BIT];
    end
    if (wr_en && wa_r == cbt_pkg::OFF_IEN) ien_nxt = wd[cbt_pkg::NUM_FLAGS-1:0];
    if (wr_en && !init_act && wa_r == cbt_pkg::OFF_FLG)
      flg_nxt = flg_nxt & ~wd[cbt_pkg::NUM_FLAGS-1:0];
    flg_nxt = flg_nxt | evt;
    if (init_act) flg_nxt = '0; // flags held cleared in init
    irq_nxt = |(flg_nxt & ien_nxt);
    rd_nxt  = 32'h0000_0000;
    case (i_haddr)
      cbt_pkg::OFF_BTR0: rd_nxt[7:0] = btr0_r;
      cbt_pkg::OFF_BTR1: rd_nxt[7:0] = btr1_r;
      cbt_pkg::OFF_CTL: begin
        rd_nxt[cbt_pkg::CTL_REQ_BIT] = req_r;
        rd_nxt[cbt_pkg::CTL_SEL_BIT] = sel_r;
        rd_nxt[cbt_pkg::CTL_ACK_BIT] = ack_r;
      end
      cbt_pkg::OFF_FLG: rd_nxt[cbt_pkg::NUM_FLAGS-1:0] = flg_r;
      cbt_pkg::OFF_IEN: rd_nxt[cbt_pkg::NUM_FLAGS-1:0] = ien_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // register stage; zero wait states, so hreadyout stays high
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      btr0_r <= cbt_pkg::RST_BTR0;
      btr1_r <= cbt_pkg::RST_BTR1;
      req_r <= 1'b0;
      ack_r <= 1'b0;
      sel_r <= 1'b0;
      flg_r <= '0;
      ien_r <= '0;
      wr_q_r <= 1'b0;
      wa_r <= 8'h00;
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      btr0_r <= btr0_nxt;
      btr1_r <= btr1_nxt;
      req_r <= req_nxt;
      ack_r <= req_r; // handshake one cycle behind request
      sel_r <= sel_nxt;
      flg_r <= flg_nxt;
      ien_r <= ien_nxt;
      wr_q_r <= wr_q_nxt;
      wa_r <= wa_nxt;
      o_hrdata <= rd_nxt;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_irq <= irq_nxt;
    end
  end

  // ----------------------------------------------------------
  // bus line synchroniser and quantum prescaler
  // ----------------------------------------------------------
  logic [2:0] rx_sy_r;
  logic       rx_s_r, rx_s_nxt, edge_r, edge_nxt, mtick, tq;
  logic [5:0] pre_r, pre_nxt;

  // filtered level: only moves when stages two and three agree
  assign rx_s_nxt = (rx_sy_r[1] == rx_sy_r[2]) ? rx_sy_r[2] : rx_s_r;
  assign mtick = sel_r ? 1'b1 : i_osc_tick;
  assign tq = mtick & !init_act & pre_r == btr0_r.quantum_prescaler;

  always_comb begin
    pre_nxt = pre_r;
    if (init_act) pre_nxt = 6'h00;
    else if (mtick) pre_nxt = tq ? 6'h00 : pre_r + 6'h01;
    // falling edge held until the next quantum consumes it
    edge_nxt = (edge_r & !tq) | (rx_s_r & !rx_s_nxt);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_sy_r <= 3'h7;
      rx_s_r <= 1'b1;
      edge_r <= 1'b0;
      pre_r <= 6'h00;
    end else begin
      rx_sy_r <= {rx_sy_r[1:0], i_can_rx};
      rx_s_r <= rx_s_nxt;
      edge_r <= edge_nxt;
      pre_r <= pre_nxt;
    end
  end

  // ----------------------------------------------------------
  // bit phase sequencer, resync and sampling
  // ----------------------------------------------------------
  cbt_pkg::cbt_phase_t ph_r, ph_nxt;
  logic [4:0] cnt_r, cnt_nxt, lim_r, lim_nxt, jmp, rem;
  logic [1:0] smp_r, smp_nxt;
  logic       rsd_r, rsd_nxt, bit_nxt, spt;
  logic       maj;

  assign jmp = 5'(btr0_r.resync_jump_width) + 5'h01;
  assign rem = lim_r - cnt_r;
  // no sample pulse on the quantum that a late edge turns into a resync
  assign spt = tq & ph_r == cbt_pkg::PH_SEG1 & cnt_r == lim_r
               & !(edge_r & !rsd_r);
  assign maj = (smp_r[1] & smp_r[0]) | (smp_r[1] & rx_s_r) | (smp_r[0] & rx_s_r);
  assign evt[cbt_pkg::FLG_RESYNC] = tq & edge_r & !rsd_r & ph_r != cbt_pkg::PH_SYNC;
  assign evt[cbt_pkg::FLG_NOISE] = spt & btr1_r.triple_sample_sel
                                   & (maj ? !(&{smp_r, rx_s_r}) : |{smp_r, rx_s_r});

  always_comb begin
    ph_nxt = ph_r;
    cnt_nxt = cnt_r;
    lim_nxt = lim_r;
    rsd_nxt = rsd_r;
    smp_nxt = smp_r;
    bit_nxt = o_rx_bit;
    if (init_act) begin
      ph_nxt = cbt_pkg::PH_SYNC;
      cnt_nxt = 5'h00;
      rsd_nxt = 1'b0;
    end else if (tq) begin
      cnt_nxt = cnt_r + 5'h01;
      case (ph_r)
        // one quantum of sync, then seg1 of field plus one
        cbt_pkg::PH_SYNC: begin
          ph_nxt = cbt_pkg::PH_SEG1;
          cnt_nxt = 5'h00;
          lim_nxt = 5'(btr1_r.first_time_segment);
          rsd_nxt = 1'b0;
        end
        cbt_pkg::PH_SEG1: begin
          smp_nxt = {smp_r[0], rx_s_r};
          if (edge_r && !rsd_r) begin
            // late edge: lengthen seg1 by phase error, capped at jump width
            lim_nxt = lim_r + ((cnt_r + 5'h01 < jmp) ? cnt_r + 5'h01 : jmp);
            rsd_nxt = 1'b1;
          end else if (cnt_r == lim_r) begin
            bit_nxt = btr1_r.triple_sample_sel ? maj : rx_s_r;
            ph_nxt = cbt_pkg::PH_SEG2;
            cnt_nxt = 5'h00;
            lim_nxt = 5'(btr1_r.second_time_segment);
          end
        end
        cbt_pkg::PH_SEG2: begin
          // early edge: if the jump covers what is left the bit ends now,
          // else the shortened limit stays above the count and is still reached
          if (edge_r && !rsd_r && rem <= jmp) begin
            ph_nxt = cbt_pkg::PH_SYNC;
          end else if (edge_r && !rsd_r) begin
            lim_nxt = lim_r - jmp;
            rsd_nxt = 1'b1;
          end else if (cnt_r == lim_r) begin
            ph_nxt = cbt_pkg::PH_SYNC;
          end
        end
        default: ph_nxt = cbt_pkg::PH_SYNC;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ph_r <= cbt_pkg::PH_SYNC;
      cnt_r <= 5'h00;
      lim_r <= 5'h00;
      rsd_r <= 1'b0;
      smp_r <= 2'h3;
      o_rx_bit <= 1'b1;
      o_tq_tick <= 1'b0;
      o_sample_pt <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      lim_r <= lim_nxt;
      rsd_r <= rsd_nxt;
      smp_r <= smp_nxt;
      o_rx_bit <= bit_nxt;
      o_tq_tick <= tq;
      o_sample_pt <= spt;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  logic [5:0] gap_r;
  logic       seen_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || init_act) begin
      gap_r <= 6'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= tq ? 6'h00 : gap_r + 6'h01;
      seen_r <= seen_r | tq;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  timing_lock_a: assert property (wr_en && !init_act
    |=> $stable(btr0_r) && $stable(btr1_r))
    else $error("timing register changed outside init");
  init_write_a: assert property (wr_en && init_act && wa_r == cbt_pkg::OFF_BTR0
    |=> btr0_r == $past(wd[7:0]))
    else $error("timing write in init lost");
  quantum_div_a: assert property (tq && sel_r && seen_r
    |-> gap_r == btr0_r.quantum_prescaler)
    else $error("quantum spacing wrong");
  jump_cap_a: assert property (ph_r == cbt_pkg::PH_SEG1
    |-> lim_r <= 5'(btr1_r.first_time_segment) + jmp)
    else $error("seg1 stretched beyond jump width");
  // a count past its limit would run the segment round the whole counter
  count_bound_a: assert property (ph_r != cbt_pkg::PH_SYNC
    |-> cnt_r <= lim_r)
    else $error("segment count passed its limit");
  sync_seg1_a: assert property (ph_r == cbt_pkg::PH_SYNC && tq && !init_act
    |=> ph_r == cbt_pkg::PH_SEG1 && cnt_r == 5'h00
        && lim_r == 5'(btr1_r.first_time_segment))
    else $error("seg1 start wrong");
  seg2_len_a: assert property (spt && !edge_r
    |=> ph_r == cbt_pkg::PH_SEG2 && lim_r == 5'(btr1_r.second_time_segment))
    else $error("seg2 length wrong");
  single_triple_sample_sel_a: assert property (spt && !edge_r && !btr1_r.triple_sample_sel
    |=> o_rx_bit == $past(rx_s_r))
    else $error("single sample mismatch");
  triple_triple_sample_sel_a: assert property (spt && !edge_r && btr1_r.triple_sample_sel
    |=> o_rx_bit == $past(maj))
    else $error("majority vote mismatch");
  flag_keep_a: assert property (evt[0] && !init_act |=> flg_r[0])
    else $error("flag event lost");
  irq_gate_a: assert property (|(flg_r & ien_r) |-> o_irq)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// ==== verilog/cbt_pkg.sv ====
`default_nettype none
package cbt_pkg;
  // ----------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------
  localparam logic [7:0] OFF_BTR0 = 8'h00;
  localparam logic [7:0] OFF_BTR1 = 8'h04;
  localparam logic [7:0] OFF_CTL  = 8'h08;
  localparam logic [7:0] OFF_FLG  = 8'h0c;
  localparam logic [7:0] OFF_IEN  = 8'h10;
  // ----------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------
  localparam logic [7:0] RST_BTR0 = 8'h00;
  localparam logic [7:0] RST_BTR1 = 8'h00;
  localparam int CTL_REQ_BIT = 0;
  localparam int CTL_SEL_BIT = 1;
  localparam int CTL_ACK_BIT = 8;
  localparam int FLG_RESYNC  = 0;
  localparam int FLG_NOISE   = 1;
  localparam int NUM_FLAGS   = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ----------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------
  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic [5:0] quantum_prescaler;
  } cbt_prescale_jump_t;
  typedef struct packed {
    logic       triple_sample_sel;
    logic [2:0] second_time_segment;
    logic [3:0] first_time_segment;
  } cbt_segments_t;
  // bit phase, gray along sync -> seg1 -> seg2
  typedef enum logic [1:0] {
    PH_SYNC = 2'h0,
    PH_SEG1 = 2'h1,
    PH_SEG2 = 2'h3
  } cbt_phase_t;
endpackage
`default_nettype wire

// ==== testbench/cbt_can_node.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------
// far node: one byte msb first, recessive otherwise
// ------
module cbt_can_node (
  // control from the bench
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_bits,
  input  wire logic [7:0] i_bit_cycles,
  // bus line
  output logic            o_rx
);
  int cnt = 0;
  int idx = 0;
  // bit counter; the line is driven high when no bit is sent, so idle reads recessive
  always @(posedge i_clk) begin
    if (i_start) begin
      idx <= 8;
      cnt <= 0;
    end else if (idx > 0) begin
      cnt <= (cnt + 1 == int'(i_bit_cycles)) ? 0 : cnt + 1;
      if (cnt + 1 == int'(i_bit_cycles)) begin
        idx <= idx - 1;
      end
    end
  end
  assign o_rx = (idx > 0) ? i_bits[idx-1] : 1'b1;
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic        hwrite   = 1'b0;
  logic        osc      = 1'b0;
  logic        nd_start = 1'b0;
  logic [7:0]  haddr    = 8'h00;
  logic [7:0]  nd_bits  = 8'h00;
  logic [7:0]  nd_cyc   = 8'h10;
  logic [1:0]  htrans   = 2'h0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, rx, tq, sp, rx_bit, irq;
  int          num_errors = 0;
  int          comparisons = 0;
  // ------
  // clock, oscillator enable, design and far node
  // ------
  always #5 clk = ~clk;
  always @(posedge clk) osc <= ~osc;
  cbt_bit_timing u_dut (.i_sys_clk(clk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_osc_tick(osc), .i_can_rx(rx), .o_tq_tick(tq), .o_sample_pt(sp),
    .o_rx_bit(rx_bit), .o_irq(irq));
  cbt_can_node u_node (.i_clk(clk), .i_start(nd_start), .i_bits(nd_bits),
    .i_bit_cycles(nd_cyc), .o_rx(rx));
  // ------
  // bus and compare tasks
  // ------
  // entered just after a rising edge; holds each phase until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    htrans <= cbt_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    check("hresp okay", 32'h0, {31'h0, hresp});
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // cycles between two pulses of the quantum or sample strobe
  task automatic gap(input bit use_sp, output int n);
    n = 0;
    do @(posedge clk); while ((use_sp ? sp : tq) !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while ((use_sp ? sp : tq) !== 1'b1);
  endtask
  task automatic send(input logic [7:0] bits, input logic [7:0] cyc);
    nd_bits  <= bits;
    nd_cyc   <= cyc;
    nd_start <= 1'b1;
    @(posedge clk);
    nd_start <= 1'b0;
  endtask
  // enter init, program timing, leave init with the chosen clock
  task automatic setup(input logic [7:0] b0, input logic [7:0] b1, input logic sel);
    bus(1'b1, cbt_pkg::OFF_CTL, 32'h1);
    repeat (2) @(posedge clk);
    bus(1'b0, cbt_pkg::OFF_CTL, 32'h0);
    check("init handshake", 32'h101, rd & 32'h101);
    bus(1'b1, cbt_pkg::OFF_BTR0, {24'h0, b0});
    bus(1'b1, cbt_pkg::OFF_BTR1, {24'h0, b1});
    bus(1'b1, cbt_pkg::OFF_CTL, {30'h0, sel, 1'b1});
    bus(1'b0, cbt_pkg::OFF_BTR1, 32'h0);
    check("segments in init", {24'h0, b1}, rd);
    bus(1'b1, cbt_pkg::OFF_CTL, {30'h0, sel, 1'b0});
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs();
    bus(1'b0, cbt_pkg::OFF_BTR0, 32'h0);
    check("prescale reset", {24'h0, cbt_pkg::RST_BTR0}, rd);
    bus(1'b1, cbt_pkg::OFF_BTR0, 32'h55);
    bus(1'b0, cbt_pkg::OFF_BTR0, 32'h0);
    check("prescale locked", 32'h0, rd);
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped read", 32'h0, rd);
    $display("test regs done");
  endtask
  // seg1 4 quanta, seg2 2 quanta: bit is 7 quanta
  task automatic t_timing(input logic [7:0] b0, input logic sel, input int p);
    int n;
    setup(b0, 8'h13, sel);
    gap(1'b0, n);
    check("quantum gap", p, n);
    gap(1'b1, n);
    check("bit gap", p * 7, n);
    $display("test timing done");
  endtask
  task automatic t_rx(input logic [7:0] b1);
    int n;
    setup(8'h02, b1, 1'b1);
    send(8'h00, 8'h15);
    repeat (3) gap(1'b1, n);
    check("rx dominant", 32'h0, {31'h0, rx_bit});
    repeat (12) gap(1'b1, n);
    check("rx recessive", 32'h1, {31'h0, rx_bit});
    $display("test rx done");
  endtask
  // mismatched far-node rate forces resynchronisation, widest jump width
  task automatic t_irq();
    int n;
    setup(8'hc2, 8'h93, 1'b1);
    bus(1'b0, cbt_pkg::OFF_FLG, 32'h0);
    check("flags after init", 32'h0, rd);
    send(8'h55, 8'h1e);
    repeat (14) gap(1'b1, n);
    bus(1'b0, cbt_pkg::OFF_FLG, 32'h0);
    check("resync flag", 32'h1, rd & 32'h1);
    check("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, cbt_pkg::OFF_IEN, 32'h1);
    repeat (2) @(posedge clk);
    check("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, cbt_pkg::OFF_FLG, 32'h1);
    repeat (2) @(posedge clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ------
  // main sequence and watchdog
  // ------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_timing(8'h02, 1'b1, 3);
    t_timing(8'h02, 1'b0, 6);
    t_timing(8'h3f, 1'b1, 64);
    t_rx(8'h13);
    t_rx(8'h93);
    t_irq();
    stop_test();
  end
  // run needs a few thousand cycles; 50k means a hang
  initial begin
    #500000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
